// >>> rtl/cri_irq_status.sv
// charger and regulator status, masks, acks and interrupt pin
`timescale 1ns/1ps
`default_nettype none
module cri_irq_status #(
	parameter longint TAPER_CYCLES = cri_pkg::TAPER_DELAY_CYCLES
) (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire cri_pkg::cri_reg_req_s req,
	output logic [7:0] rd_data,
	input wire cri_pkg::cri_charge_cond_s charge_cond,
	input wire cri_pkg::cri_reg_cond_s reg_cond,
	input wire logic rails_off_wait,
	input wire logic linear_reg_one_en,
	input wire logic linear_reg_two_en,
	input wire logic core_lowpower_off,
	output logic irq_n,
	output logic [7:0] charger_config,
	output logic charger_reset_req
);
	import cri_pkg::*;

	function automatic logic hit(cri_reg_req_s r, logic [7:0] a);
		return r.addr == a;
	endfunction

	localparam logic [TIMER_W-1:0] TAPER_LAST =
		TIMER_W'(TAPER_CYCLES - 1);

	logic [SYNC_W-1:0] sync_q1;
	logic [SYNC_W-1:0] sync_q2;
	cri_charge_cond_s charge_s;
	cri_reg_cond_s reg_s;
	logic wait_clr;

	logic [TIMER_W-1:0] taper_cnt;
	logic taper_done;

	logic [7:0] charge_in;
	logic [7:0] reg_in;
	logic [7:0] charge_status;
	logic [7:0] charge_ack;
	logic [7:0] regulator_status;
	logic [7:0] regulator_ack;
	logic [7:0] charge_irq_mask;
	logic [7:0] regulator_irq_mask;
	logic charge_pend;
	logic reg_pend;

	logic wr_charge;
	logic [7:0] charge_clr;
	logic rd_charge;
	logic rd_reg;

	// analog and pin levels are asynchronous, two flops before use
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			sync_q1 <= SYNC_RESET;
			sync_q2 <= SYNC_RESET;
		end else begin
			sync_q1 <= {rails_off_wait, reg_cond, charge_cond};
			sync_q2 <= sync_q1;
		end
	end

	assign charge_s = sync_q2[7:0];
	assign reg_s = sync_q2[14:8];
	// all rails off in wait mode returns every register to default
	assign wait_clr = sync_q2[15];

	// taper timer runs only while enabled and comparator is high
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			taper_cnt <= '0;
			taper_done <= 1'b0;
		end else if (wait_clr || charger_reset_req ||
			!charger_config[CFG_TIMER_EN_BIT] || !charge_s.taper_cmp) begin
			taper_cnt <= '0;
			taper_done <= 1'b0;
		end else if (taper_cnt == TAPER_LAST) begin
			taper_done <= 1'b1;
		end else begin
			taper_cnt <= taper_cnt + 1'b1;
		end
	end

	// condition vectors in register bit order
	always_comb begin
		charge_in[7] = charge_s.usb_valid;
		charge_in[6] = charge_s.ac_valid;
		charge_in[5] = charge_s.thermal_suspend;
		charge_in[4] = charge_s.term_current;
		// direct comparator is seen TAPER_CYCLES cycles earlier than timer
		charge_in[3] = charger_config[CFG_TIMER_EN_BIT] ?
			taper_done : charge_s.taper_cmp;
		charge_in[2] = charge_s.fast_timeout;
		charge_in[1] = charge_s.pre_timeout;
		charge_in[0] = charge_s.batt_temp_err;
		reg_in[7] = reg_s.power_button_request;
		reg_in[6] = ~reg_s.battery_lid_input;
		reg_in[5] = reg_s.undervoltage_lockout;
		reg_in[4] = 1'b0;
		reg_in[3] = reg_s.linear_reg_two_fault & linear_reg_two_en;
		reg_in[2] = reg_s.linear_reg_one_fault & linear_reg_one_en;
		reg_in[1] = reg_s.main_fault;
		reg_in[0] = reg_s.core_fault | core_lowpower_off;
	end

	assign wr_charge = req.wr && hit(req, ADDR_CHARGE_STATUS);
	// only bits 1-4 clear; other bits of the write are dropped
	assign charge_clr = CHARGE_CLEARABLE & ~req.wdata;
	assign rd_charge = req.rd && hit(req, ADDR_CHARGE_STATUS);
	assign rd_reg = req.rd && hit(req, ADDR_REGULATOR_STATUS);

	cri_status_group #(
		.EDGE_BITS(CHARGE_EDGE_BITS),
		.LIVE_BITS(CHARGE_LIVE_BITS)
	) u_charge (
		.sys_clk(sys_clk),
		.rstn(rstn),
		.soft_clr(wait_clr),
		.cond(charge_in),
		.rd_ack(rd_charge),
		.mask(charge_irq_mask),
		.status(charge_status),
		.ack(charge_ack),
		.pending(charge_pend)
	);

	cri_status_group #(
		.EDGE_BITS(REG_EDGE_BITS),
		.LIVE_BITS(REG_LIVE_BITS)
	) u_reg (
		.sys_clk(sys_clk),
		.rstn(rstn),
		.soft_clr(wait_clr),
		.cond(reg_in),
		.rd_ack(rd_reg),
		.mask(regulator_irq_mask),
		.status(regulator_status),
		.ack(regulator_ack),
		.pending(reg_pend)
	);

	// writable registers
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			charge_irq_mask <= RESET_MASK;
			regulator_irq_mask <= RESET_MASK;
			charger_config <= RESET_CONFIG;
		end else if (wait_clr) begin
			charge_irq_mask <= RESET_MASK;
			regulator_irq_mask <= RESET_MASK;
			charger_config <= RESET_CONFIG;
		end else if (req.wr) begin
			if (hit(req, ADDR_CHARGE_IRQ_MASK))
				charge_irq_mask <= req.wdata;
			if (hit(req, ADDR_REGULATOR_IRQ_MASK))
				regulator_irq_mask <= req.wdata;
			if (hit(req, ADDR_CHARGER_CONFIG))
				charger_config <= req.wdata;
		end
	end

	// reset request: status write clearing bits 1-4, or config bit
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			charger_reset_req <= 1'b0;
		end else if (wait_clr) begin
			charger_reset_req <= 1'b0;
		end else begin
			charger_reset_req <= (wr_charge && |charge_clr) ||
				charger_config[CFG_CHG_RESET_BIT];
		end
	end

	// read data is registered, one cycle after the read strobe
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			rd_data <= 8'h00;
		end else if (req.rd) begin
			case (req.addr)
				ADDR_CHARGE_STATUS: rd_data <= charge_status;
				ADDR_REGULATOR_STATUS: rd_data <= regulator_status;
				ADDR_CHARGE_IRQ_MASK: rd_data <= charge_irq_mask;
				ADDR_REGULATOR_IRQ_MASK: rd_data <= regulator_irq_mask;
				ADDR_CHARGE_IRQ_ACK: rd_data <= charge_ack;
				ADDR_REGULATOR_IRQ_ACK: rd_data <= regulator_ack;
				ADDR_CHARGER_CONFIG: rd_data <= charger_config;
				default: rd_data <= UNMAPPED_READ;
			endcase
		end
	end

	// interrupt pin, active low; masks already at defaults in wait clear
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			irq_n <= 1'b1;
		end else begin
			irq_n <= ~(charge_pend | reg_pend);
		end
	end

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rstn);

	usb_follow_a: assert property (
		!wait_clr && charge_s.usb_valid |=> charge_status[7]
	) else $error("usb status did not follow source");

	usb_level_a: assert property (
		!wait_clr |=> charge_status[7:6] == $past(charge_s[7:6])
	) else $error("source bits do not follow condition");

	ignore_write_a: assert property (
		wr_charge && !wait_clr && charge_status[0] && !charge_ack[0]
		|=> charge_status[0]
	) else $error("write changed a read-only charge bit");

	taper_direct_a: assert property (
		!wait_clr && !charger_config[CFG_TIMER_EN_BIT]
		|=> charge_status[TAPER_BIT] == $past(charge_s.taper_cmp)
	) else $error("taper bit not following comparator");

	taper_wait_a: assert property (
		charger_config[CFG_TIMER_EN_BIT] && !taper_done && !wait_clr &&
		taper_cnt != TAPER_LAST |=> !taper_done &&
		!charge_status[TAPER_BIT]
	) else $error("taper shown before timer expired");

	taper_expire_a: assert property (
		charger_config[CFG_TIMER_EN_BIT] && charge_s.taper_cmp &&
		taper_cnt == TAPER_LAST && !wait_clr && !charger_reset_req
		|=> taper_done
	) else $error("taper timer missed expiry");

	reset_req_a: assert property (
		wr_charge && |charge_clr && !wait_clr |=> charger_reset_req
	) else $error("charger reset not requested");

	read_ack_a: assert property (
		rd_charge && !wait_clr |=>
		((charge_ack | ~charge_status) & $past(charge_status)) ==
		$past(charge_status)
	) else $error("read did not acknowledge set bits");

	ack_clear_a: assert property (
		(charge_ack & ~charge_status) == 8'h00 &&
		(regulator_ack & ~regulator_status) == 8'h00
	) else $error("ack bit without status bit");

	bit4_zero_a: assert property (
		!regulator_status[4] && !regulator_ack[4]
	) else $error("unused regulator bit set");

	edge_hold_a: assert property (
		!wait_clr && charge_status[5] && !charge_ack[5]
		|=> charge_status[5]
	) else $error("edge bit lost before acknowledge");

	edge_release_a: assert property (
		!wait_clr && regulator_status[7] && regulator_ack[7] &&
		!reg_in[7] |=> !regulator_status[7]
	) else $error("edge bit not released after ack");

	lid_invert_a: assert property (
		!wait_clr && $fell(reg_s.battery_lid_input)
		|=> regulator_status[REG_LID_BIT]
	) else $error("lid bit not set on low pin");

	ldo_off_a: assert property (
		!linear_reg_one_en && !linear_reg_two_en && !wait_clr
		|=> !regulator_status[3] && !regulator_status[2]
	) else $error("disabled regulator flagged");

	irq_low_a: assert property (
		charge_status[2] && !charge_irq_mask[2] && !charge_ack[2]
		|=> !irq_n
	) else $error("unmasked charge bit missed interrupt");

	irq_high_a: assert property (
		charge_irq_mask == 8'hff && regulator_irq_mask == 8'hff
		|=> irq_n
	) else $error("masked bits drove interrupt");

	irq_reg_a: assert property (
		$rose(regulator_status[1]) && !regulator_irq_mask[1] &&
		!regulator_ack[1] |=> !irq_n
	) else $error("regulator edge missed interrupt");

	unmapped_a: assert property (
		req.rd && (req.addr == 8'h00 || req.addr > ADDR_CHARGER_CONFIG)
		|=> rd_data == UNMAPPED_READ
	) else $error("unlisted address did not read all ones");

	mask_write_a: assert property (
		req.wr && hit(req, ADDR_CHARGE_IRQ_MASK) && !wait_clr
		|=> charge_irq_mask == $past(req.wdata)
	) else $error("charge mask write lost");

	reg_mask_write_a: assert property (
		req.wr && hit(req, ADDR_REGULATOR_IRQ_MASK) && !wait_clr
		|=> regulator_irq_mask == $past(req.wdata)
	) else $error("regulator mask write lost");

	wait_default_a: assert property (
		wait_clr |=> charge_irq_mask == RESET_MASK &&
		regulator_irq_mask == RESET_MASK && charger_config == RESET_CONFIG
	) else $error("wait mode did not restore defaults");

	main_level_a: assert property (
		!wait_clr |=> regulator_status[1] == $past(reg_s.main_fault)
	) else $error("main fault bit not following condition");

	reg_read_ack_a: assert property (
		rd_reg && !wait_clr |=>
		((regulator_ack | ~regulator_status) & $past(regulator_status)) ==
		$past(regulator_status)
	) else $error("read did not acknowledge regulator bits");
endmodule
`default_nettype wire

// >>> rtl/cri_pkg.sv
// shared constants and carriers for the charger/regulator status block
package cri_pkg;
	// register addresses on the serial register port
	localparam logic [7:0] ADDR_CHARGE_STATUS = 8'h01;
	localparam logic [7:0] ADDR_REGULATOR_STATUS = 8'h02;
	localparam logic [7:0] ADDR_CHARGE_IRQ_MASK = 8'h03;
	localparam logic [7:0] ADDR_REGULATOR_IRQ_MASK = 8'h04;
	localparam logic [7:0] ADDR_CHARGE_IRQ_ACK = 8'h05;
	localparam logic [7:0] ADDR_REGULATOR_IRQ_ACK = 8'h06;
	localparam logic [7:0] ADDR_CHARGER_CONFIG = 8'h07;
	// values after reset and for unlisted addresses
	localparam logic [7:0] RESET_STATUS = 8'h00;
	localparam logic [7:0] RESET_ACK = 8'h00;
	localparam logic [7:0] RESET_MASK = 8'hff;
	localparam logic [7:0] RESET_CONFIG = 8'h1b;
	localparam logic [7:0] UNMAPPED_READ = 8'hff;
	// field layouts
	localparam logic [7:0] CHARGE_EDGE_BITS = 8'h21;
	localparam logic [7:0] CHARGE_LIVE_BITS = 8'hff;
	localparam logic [7:0] CHARGE_CLEARABLE = 8'h1e;
	localparam logic [7:0] REG_EDGE_BITS = 8'he0;
	localparam logic [7:0] REG_LIVE_BITS = 8'hef;
	localparam int CFG_TIMER_EN_BIT = 5;
	localparam int CFG_CHG_RESET_BIT = 6;
	localparam int TAPER_BIT = 3;
	localparam int REG_LID_BIT = 6;
	// pin synchroniser: 8 charge, 7 regulator, 1 wait-mode clear
	localparam int SYNC_W = 16;
	localparam logic [15:0] SYNC_RESET = 16'h2000;
	// taper delay: minutes to cycles at a 4 ns clock
	localparam longint CLK_PERIOD_PS = 4000;
	localparam longint TAPER_DELAY_MIN = 30;
	// one second in ps, sized: too wide for a plain 32-bit literal
	localparam longint PS_PER_SEC = 64'he8d4a51000;
	localparam longint TAPER_DELAY_CYCLES =
		TAPER_DELAY_MIN * 60 * PS_PER_SEC / CLK_PERIOD_PS;
	localparam int TIMER_W = 40;

	typedef struct packed {
		logic usb_valid;
		logic ac_valid;
		logic thermal_suspend;
		logic term_current;
		logic taper_cmp;
		logic fast_timeout;
		logic pre_timeout;
		logic batt_temp_err;
	} cri_charge_cond_s;

	typedef struct packed {
		logic power_button_request;
		logic battery_lid_input;
		logic undervoltage_lockout;
		logic linear_reg_two_fault;
		logic linear_reg_one_fault;
		logic main_fault;
		logic core_fault;
	} cri_reg_cond_s;

	typedef struct packed {
		logic rd;
		logic wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} cri_reg_req_s;
endpackage

// >>> rtl/cri_status_group.sv
// one status register with its auto-acknowledge bits
`timescale 1ns/1ps
`default_nettype none
module cri_status_group #(
	parameter logic [7:0] EDGE_BITS = 8'h00,
	parameter logic [7:0] LIVE_BITS = 8'hff
) (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic soft_clr,
	input wire logic [7:0] cond,
	input wire logic rd_ack,
	input wire logic [7:0] mask,
	output logic [7:0] status,
	output logic [7:0] ack,
	output logic pending
);
	import cri_pkg::*;

	logic [7:0] cond_q;
	logic [7:0] next_status;
	logic [7:0] next_ack;

	for (genvar i = 0; i < 8; i++) begin : g_bit
		if (!LIVE_BITS[i]) begin : g_none
			assign next_status[i] = 1'b0;
			assign next_ack[i] = 1'b0;
		end else begin : g_live
			logic set_ev;
			logic hold;
			// edge bits latch; level bits follow, so set wins
			assign set_ev = EDGE_BITS[i] ? (cond[i] & ~cond_q[i]) : cond[i];
			assign hold = EDGE_BITS[i] & status[i] & (cond[i] | ~ack[i]);
			assign next_status[i] = set_ev | hold;
			// ack is taken from the value being read out
			assign next_ack[i] = next_status[i] &
				(ack[i] | (rd_ack & status[i]));
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			status <= RESET_STATUS;
			ack <= RESET_ACK;
			cond_q <= 8'h00;
		end else if (soft_clr) begin
			status <= RESET_STATUS;
			ack <= RESET_ACK;
			cond_q <= 8'h00;
		end else begin
			status <= next_status;
			ack <= next_ack;
			cond_q <= cond;
		end
	end

	assign pending = |(status & ~mask & ~ack);
endmodule
`default_nettype wire

// >>> verif/charger_regulator_irq_status_bench.sv
// self-checking bench for the charger and regulator status block
`timescale 1ns/1ps
`default_nettype none
module charger_regulator_irq_status_bench;
	import cri_pkg::*;
	// short taper count keeps the run brief
	localparam longint TAPER = 20;
	logic sys_clk = 1'b0;
	logic rstn = 1'b0;
	cri_reg_req_s req;
	cri_charge_cond_s cc = '0;
	cri_reg_cond_s rc = 7'h20;
	logic rails = 1'b0;
	logic en1 = 1'b1;
	logic en2 = 1'b1;
	logic lp = 1'b0;
	logic [7:0] rd_data;
	logic [7:0] cfg;
	logic irq_n;
	logic rst_req;
	logic [7:0] s, m;
	int failures = 0;
	int checked = 0;
	int seed = 32'h8af7;
	int n;
	logic [7:0] ra [8] = '{8'h01, 8'h02, 8'h03, 8'h04,
		8'h05, 8'h06, 8'h07, 8'h20};
	logic [7:0] rv [8] = '{8'h00, 8'h00, 8'hff, 8'hff,
		8'h00, 8'h00, 8'h1b, 8'hff};

	always #2 sys_clk = ~sys_clk;

	cri_irq_status #(.TAPER_CYCLES(TAPER)) cri_irq_status_i (
		.sys_clk(sys_clk), .rstn(rstn), .req(req), .rd_data(rd_data),
		.charge_cond(cc), .reg_cond(rc), .rails_off_wait(rails),
		.linear_reg_one_en(en1), .linear_reg_two_en(en2),
		.core_lowpower_off(lp), .irq_n(irq_n),
		.charger_config(cfg), .charger_reset_req(rst_req));

	cri_host_model cri_host_model_i (
		.sys_clk(sys_clk), .rd_data(rd_data), .req(req));

	function automatic logic [7:0] exp_reg(input cri_reg_cond_s c,
		input logic e1, e2, l);
		return {c.power_button_request, ~c.battery_lid_input,
			c.undervoltage_lockout, 1'b0,
			c.linear_reg_two_fault & e2, c.linear_reg_one_fault & e1,
			c.main_fault, c.core_fault | l};
	endfunction

	// level interrupt: any status bit not masked; acks are not modelled and taken as clear
	function automatic logic [7:0] exp_irq(input logic [7:0] st, mk);
		return {7'h00, ~|(st & ~mk)};
	endfunction

	task automatic end_sim;
		if (failures == 0 && checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, want, input string msg);
		checked++;
		if (got !== want) begin
			failures++;
			$display("wrong value at %0t: %s got %h want %h",
				$time, msg, got, want);
		end
	endtask

	task automatic cyc(input int k);
		repeat (k) @(negedge sys_clk);
	endtask

	task automatic wr(input logic [7:0] a, d);
		logic [7:0] q;
		cri_host_model_i.access(1'b1, a, d, q);
	endtask

	task automatic rdchk(input logic [7:0] a, want, input string msg);
		logic [7:0] q;
		cri_host_model_i.access(1'b0, a, 8'h00, q);
		chk(q, want, msg);
	endtask

	initial begin
		repeat (16) @(posedge sys_clk);
		@(negedge sys_clk);
		rstn = 1'b1;
		chk({7'h00, irq_n}, 8'h01, "irq after reset");
		chk(cfg, 8'h1b, "config after reset");
		for (int i = 0; i < 8; i++) begin
			rdchk(ra[i], rv[i], "reset value");
			if (rv[i] == 8'h00) begin
				wr(ra[i], 8'hff);
				rdchk(ra[i], 8'h00, "read-only kept");
			end
		end
		// random charge levels and masks, levels all ones on the first pass, mask all ones on the second
		for (int i = 0; i < 8; i++) begin
			s = (i == 0) ? 8'hff : 8'($random(seed));
			m = (i == 1) ? 8'hff : 8'($random(seed));
			wr(8'h03, m);
			rdchk(8'h03, m, "charge mask");
			cc = s;
			cyc(6);
			chk({7'h00, irq_n}, exp_irq(s, m), "charge irq");
			rdchk(8'h01, s, "charge status");
			rdchk(8'h05, s, "charge ack");
			cyc(2);
			chk({7'h00, irq_n}, 8'h01, "acked irq");
			cc = '0;
			cyc(6);
			rdchk(8'h01, 8'h00, "charge cleared");
			rdchk(8'h05, 8'h00, "charge ack cleared");
		end
		// short pulse: edge bits hold until read, level bits drop
		wr(8'h03, 8'hde);
		cc = 8'hff;
		cyc(4);
		cc = '0;
		cyc(6);
		chk({7'h00, irq_n}, 8'h00, "edge irq held");
		rdchk(8'h01, 8'h21, "edge bits held");
		cyc(2);
		rdchk(8'h01, 8'h00, "edge bits released");
		// clearing write requests a charger reset, stores nothing
		// bit 0 pending unacked, so the write must leave it alone
		cc = 8'h81;
		cyc(6);
		wr(8'h01, 8'h00);
		chk({7'h00, rst_req}, 8'h01, "reset request");
		cyc(1);
		chk({7'h00, rst_req}, 8'h00, "reset request ends");
		wr(8'h07, 8'h5b);
		cyc(1);
		chk({7'h00, rst_req}, 8'h01, "config reset request");
		wr(8'h07, 8'h1b);
		cyc(1);
		chk({7'h00, rst_req}, 8'h00, "config reset released");
		rdchk(8'h01, 8'h81, "status write ignored");
		cc = '0;
		cyc(6);
		// regulator group, random conditions, enables and masks
		for (int i = 0; i < 8; i++) begin
			rc = (i == 0) ? 7'h5f : 7'($random(seed));
			{en1, en2, lp} = (i == 0) ? 3'b110 : 3'($random(seed));
			m = 8'($random(seed));
			wr(8'h04, m);
			s = exp_reg(rc, en1, en2, lp);
			cyc(6);
			chk({7'h00, irq_n}, exp_irq(s, m), "reg irq");
			rdchk(8'h02, s, "reg status");
			rdchk(8'h06, s, "reg ack");
			rc = 7'h20;
			{en1, en2, lp} = 3'b110;
			cyc(6);
			rdchk(8'h02, 8'h00, "reg cleared");
			rdchk(8'h06, 8'h00, "reg ack cleared");
		end
		// timer on: taper bit only after the count runs out
		wr(8'h07, 8'h3b);
		chk(cfg, 8'h3b, "config write");
		wr(8'h03, 8'hf7);
		cc.taper_cmp = 1'b1;
		n = 0;
		while (irq_n !== 1'b0 && n <= 200) begin
			cyc(1);
			n++;
		end
		chk(8'(n >= TAPER && n <= TAPER + 8), 8'h01, "taper delay");
		// wait mode with all rails off returns defaults
		cc = '0;
		rails = 1'b1;
		cyc(4);
		rails = 1'b0;
		cyc(4);
		chk(cfg, 8'h1b, "config after wait mode");
		rdchk(8'h03, 8'hff, "mask after wait mode");
		chk({7'h00, irq_n}, 8'h01, "irq after wait mode");
		end_sim();
	end
endmodule
`default_nettype wire

// >>> verif/cri_host_model.sv
// host side model issuing register reads and writes
`timescale 1ns/1ps
`default_nettype none
module cri_host_model (
	input wire logic sys_clk,
	input wire logic [7:0] rd_data,
	output var cri_pkg::cri_reg_req_s req
);
	import cri_pkg::*;

	initial begin
		req = '0;
	end

	// one access per call, held across the taking edge; a write that
	// clears bits 1-4 of charge status asks for a charger reset
	task automatic access(input logic w, input logic [7:0] a,
		input logic [7:0] d, output logic [7:0] q);
		@(negedge sys_clk);
		req = '{rd: !w, wr: w, addr: a, wdata: d};
		@(negedge sys_clk);
		req = '0;
		q = rd_data;
	endtask
endmodule
`default_nettype wire
